// ---- shared/safety_timing_relay_defines.vh ----
// Constants for the safety timing relay: modes, time bases, codes and timing
`ifndef SAFETY_TIMING_RELAY_DEFINES_VH
`define SAFETY_TIMING_RELAY_DEFINES_VH

// Switching modes
`define MODE_ON_DELAY 3'h0
`define MODE_OFF_DELAY 3'h1
`define MODE_OFF_RETRIG 3'h2
`define MODE_ON_OFF 3'h3
`define MODE_PULSE 3'h4
`define MODE_FLASH 3'h5

// Time bases
`define BASE_SEC 2'h0
`define BASE_MIN_SEC 2'h1
`define BASE_HR_MIN 2'h2

// Preset limits and scaling into 50 ms ticks
`define PRESET_MS_MAX 20'hf421e
`define PRESET_MS_HALF 24'h000019
`define PRESET_MS_STEP 24'h000032
`define PRESET_MS_MAX_TICKS 24'h004e1f
`define PRESET_UNIT_MAX 20'h0176f
`define TICKS_PER_SEC 24'h000014
`define TICKS_PER_MIN 24'h0004b0

// Tick period, clock rate and the derived cycle count
`define TICK_US 50000
`define CLK_MHZ 250
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)

// State encodings
`define ST_OFF 3'h0
`define ST_ARMED 3'h1
`define ST_TIME 3'h2
`define ST_HOLD 3'h3
`define ST_WAIT_FALL 3'h4
`define ST_FAULT 3'h5

// Diagnostic codes
`define DIAG_NO_ENABLE 32'h00000000
`define DIAG_WAIT_START 32'h00002001
`define DIAG_WAIT_FALL_OFF 32'h0000200b
`define DIAG_RUN_OFF 32'h0000200c
`define DIAG_STOP_OFF 32'h0000200d
`define DIAG_ACTIVE 32'h0000800c
`define DIAG_WAIT_FALL_ON 32'h0000800d
`define DIAG_RUN_ON 32'h0000800e
`define DIAG_STOP_ON 32'h0000800f
`define DIAG_FAULT 32'h0000c001

`endif

// ---- rtl/safety_timing_relay.v ----
// Safety timing relay function block with six switching modes
//
// Summary of operation
// - Diagnostic word reads 0000 without enable.
// - Code 2001 while armed awaiting trigger.
// - Codes 200B/800D while awaiting trigger fall.
// - Codes 200C/800E while preset time runs.
// - Codes 200D/800F while stop coil halts timing.
// - Code 800C when contact closed otherwise.
// - Elapsed time of current run is output.
// - Armed by activation, timing started by trigger.
// - Stop coil freezes time, resumes afterwards.
// - Error contact closes on detected error.
// - Preset scaled by time base, ms rounded.
// - On-delay closes after preset, opens on drop.
// - Early trigger drop abandons on-delay run.
// - Activation drop opens contact immediately.
// - Off-delay runs after trigger falls, then opens.
// - Non-retrig off-delay accumulates off periods.
// - Retrig off-delay restarts time on trigger.
// - On/off mode: first on, second off delay.
// - Early drop keeps open; stop idle between.
// - Single pulse closes for exactly preset time.
// - Flashing alternates first/second preset while triggered.
// - Time counted in 50 ms ticks.
// - Presets limited to 999.95 s or 99:59.
`timescale 1ns/1ps
`default_nettype none
`include "safety_timing_relay_defines.vh"

module safety_timing_relay #(
    parameter integer TICK_CYCLES = `TICK_CYCLES,
    parameter integer PRESET_W = 20,
    parameter integer TIME_W = 24
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire activation_coil_i,
    input wire trigger_coil_i,
    input wire stop_coil_i,
    input wire [2:0] mode_i,
    input wire [1:0] time_base_i,
    input wire [PRESET_W-1:0] first_preset_i,
    input wire [PRESET_W-1:0] second_preset_i,
    output reg enable_contact_o,
    output reg error_contact_o,
    output reg [TIME_W-1:0] elapsed_time_value_o,
    output reg [31:0] diagnostic_word_o
);

    // Convert a preset into 50 ms ticks
    function [TIME_W-1:0] to_ticks;
        input [1:0] base;
        input [PRESET_W-1:0] value;
        reg [TIME_W-1:0] wide;
        begin
            wide = {{(TIME_W-PRESET_W){1'b0}}, value};
            case (base)
                `BASE_SEC: to_ticks = (wide + `PRESET_MS_HALF) / `PRESET_MS_STEP;
                `BASE_MIN_SEC: to_ticks = wide * `TICKS_PER_SEC;
                default: to_ticks = wide * `TICKS_PER_MIN;
            endcase
        end
    endfunction

    // Range check of one preset
    function preset_bad;
        input [1:0] base;
        input [PRESET_W-1:0] value;
        begin
            case (base)
                `BASE_SEC: preset_bad = (value > `PRESET_MS_MAX);
                `BASE_MIN_SEC: preset_bad = (value > `PRESET_UNIT_MAX);
                `BASE_HR_MIN: preset_bad = (value > `PRESET_UNIT_MAX);
                default: preset_bad = 1'b1;
            endcase
        end
    endfunction

    // Diagnostic code for a state
    function [31:0] diag_of;
        input [2:0] st;
        input out;
        input stopped;
        begin
            case (st)
                `ST_OFF: diag_of = `DIAG_NO_ENABLE;
                `ST_ARMED: diag_of = `DIAG_WAIT_START;
                `ST_WAIT_FALL: diag_of = out ? `DIAG_WAIT_FALL_ON : `DIAG_WAIT_FALL_OFF;
                `ST_TIME: begin
                    if (stopped) begin
                        diag_of = out ? `DIAG_STOP_ON : `DIAG_STOP_OFF;
                    end else begin
                        diag_of = out ? `DIAG_RUN_ON : `DIAG_RUN_OFF;
                    end
                end
                `ST_HOLD: diag_of = out ? `DIAG_ACTIVE : `DIAG_WAIT_START;
                `ST_FAULT: diag_of = `DIAG_FAULT;
                default: diag_of = `DIAG_NO_ENABLE;
            endcase
        end
    endfunction

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [2:0] mode_ff;
    reg [2:0] nxt_mode;
    reg phase_ff;
    reg nxt_phase;
    reg out_ff;
    reg nxt_out;
    reg [TIME_W-1:0] elapsed_ff;
    reg [TIME_W-1:0] nxt_elapsed;
    reg [23:0] presc_ff;
    reg [23:0] nxt_presc;

    wire [TIME_W-1:0] first_ticks;
    wire [TIME_W-1:0] second_ticks;
    wire [TIME_W-1:0] target;
    wire cfg_bad;
    wire counting;
    wire tick;
    wire expired;

    localparam integer TICK_LAST_I = TICK_CYCLES - 1;
    localparam [23:0] TICK_LAST = TICK_LAST_I[23:0];

    assign first_ticks = to_ticks(time_base_i, first_preset_i);
    assign second_ticks = to_ticks(time_base_i, second_preset_i);
    assign target = phase_ff ? second_ticks : first_ticks;
    assign cfg_bad = preset_bad(time_base_i, first_preset_i) |
                     preset_bad(time_base_i, second_preset_i) |
                     (mode_i > `MODE_FLASH);
    assign counting = (state_ff == `ST_TIME) && !stop_coil_i;
    assign tick = counting && (presc_ff == TICK_LAST);
    // A preset that rounds to zero ticks (under 25 ms) expires at once; 25 to 74 ms presets wait one tick
    assign expired = (state_ff == `ST_TIME) && (elapsed_ff >= target);

    always @* begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_phase = phase_ff;
        nxt_out = out_ff;
        nxt_elapsed = elapsed_ff;
        // Prescaler holds while stopped so a resumed run keeps its fraction
        nxt_presc = presc_ff;
        if (counting) begin
            nxt_presc = tick ? 24'h000000 : presc_ff + 24'h000001;
        end
        if (tick) begin
            nxt_elapsed = elapsed_ff + {{(TIME_W-1){1'b0}}, 1'b1};
        end

        if (!activation_coil_i) begin
            nxt_state = `ST_OFF;
            nxt_out = 1'b0;
            nxt_phase = 1'b0;
            nxt_elapsed = {TIME_W{1'b0}};
            nxt_presc = 24'h000000;
        // mode change while active is a fault
        end else if (state_ff != `ST_OFF && state_ff != `ST_FAULT &&
                     (cfg_bad || mode_i != mode_ff)) begin
            nxt_state = `ST_FAULT;
            nxt_out = 1'b0;
        end else begin
            case (state_ff)
                `ST_OFF: begin
                    nxt_mode = mode_i;
                    nxt_state = cfg_bad ? `ST_FAULT : `ST_ARMED;
                end
                `ST_ARMED: begin
                    nxt_phase = 1'b0;
                    nxt_elapsed = {TIME_W{1'b0}};
                    nxt_presc = 24'h000000;
                    if (trigger_coil_i) begin
                        case (mode_ff)
                            `MODE_OFF_DELAY, `MODE_OFF_RETRIG: begin
                                nxt_state = `ST_HOLD;
                                nxt_out = 1'b1;
                            end
                            `MODE_PULSE, `MODE_FLASH: begin
                                nxt_state = `ST_TIME;
                                nxt_out = 1'b1;
                            end
                            default: begin
                                nxt_state = `ST_TIME;
                                nxt_out = 1'b0;
                            end
                        endcase
                    end
                end
                `ST_TIME: begin
                    case (mode_ff)
                        `MODE_ON_DELAY: begin
                            if (!trigger_coil_i) begin
                                nxt_state = `ST_ARMED;
                            end else if (expired) begin
                                nxt_state = `ST_HOLD;
                                nxt_out = 1'b1;
                            end
                        end
                        `MODE_OFF_DELAY, `MODE_OFF_RETRIG: begin
                            if (trigger_coil_i) begin
                                if (mode_ff == `MODE_OFF_RETRIG) begin
                                    nxt_state = `ST_HOLD;
                                    nxt_elapsed = {TIME_W{1'b0}};
                                    nxt_presc = 24'h000000;
                                end else begin
                                    nxt_state = `ST_WAIT_FALL;
                                end
                            end else if (expired) begin
                                nxt_state = `ST_ARMED;
                                nxt_out = 1'b0;
                            end
                        end
                        `MODE_ON_OFF: begin
                            if (!phase_ff) begin
                                if (!trigger_coil_i) begin
                                    nxt_state = `ST_ARMED;
                                end else if (expired) begin
                                    nxt_state = `ST_HOLD;
                                    nxt_out = 1'b1;
                                end
                            end else if (trigger_coil_i) begin
                                nxt_state = `ST_HOLD;
                                nxt_phase = 1'b0;
                            end else if (expired) begin
                                nxt_state = `ST_ARMED;
                                nxt_out = 1'b0;
                                nxt_phase = 1'b0;
                            end
                        end
                        `MODE_PULSE: begin
                            if (expired) begin
                                nxt_out = 1'b0;
                                nxt_state = trigger_coil_i ? `ST_WAIT_FALL : `ST_ARMED;
                            end
                        end
                        default: begin
                            if (!trigger_coil_i) begin
                                nxt_state = `ST_ARMED;
                                nxt_out = 1'b0;
                                nxt_phase = 1'b0;
                            end else if (expired) begin
                                nxt_phase = !phase_ff;
                                nxt_out = phase_ff;
                                nxt_elapsed = {TIME_W{1'b0}};
                                nxt_presc = 24'h000000;
                            end
                        end
                    endcase
                end
                `ST_HOLD: begin
                    // Stop coil has no effect here since nothing counts
                    if (!trigger_coil_i) begin
                        case (mode_ff)
                            `MODE_ON_DELAY: begin
                                nxt_state = `ST_ARMED;
                                nxt_out = 1'b0;
                            end
                            `MODE_ON_OFF: begin
                                nxt_state = `ST_TIME;
                                nxt_phase = 1'b1;
                                nxt_elapsed = {TIME_W{1'b0}};
                                nxt_presc = 24'h000000;
                            end
                            default: begin
                                nxt_state = `ST_TIME;
                            end
                        endcase
                    end
                end
                `ST_WAIT_FALL: begin
                    if (!trigger_coil_i) begin
                        nxt_state = (mode_ff == `MODE_PULSE) ? `ST_ARMED : `ST_TIME;
                    end
                end
                `ST_FAULT: begin
                    // Only dropping activation acknowledges a fault
                    nxt_out = 1'b0;
                end
                default: begin
                    nxt_state = `ST_OFF;
                    nxt_out = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= `ST_OFF;
            mode_ff <= `MODE_ON_DELAY;
            phase_ff <= 1'b0;
            out_ff <= 1'b0;
            elapsed_ff <= {TIME_W{1'b0}};
            presc_ff <= 24'h000000;
            enable_contact_o <= 1'b0;
            error_contact_o <= 1'b0;
            elapsed_time_value_o <= {TIME_W{1'b0}};
            diagnostic_word_o <= `DIAG_NO_ENABLE;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            phase_ff <= nxt_phase;
            out_ff <= nxt_out;
            elapsed_ff <= nxt_elapsed;
            presc_ff <= nxt_presc;
            enable_contact_o <= nxt_out;
            error_contact_o <= (nxt_state == `ST_FAULT);
            elapsed_time_value_o <= nxt_elapsed;
            diagnostic_word_o <= diag_of(nxt_state, nxt_out, stop_coil_i);
        end
    end

endmodule // safety_timing_relay
`default_nettype wire

// ---- tb/relay_checker_sva.sv ----
// Port-level assertions for the safety timing relay
`timescale 1ns/1ps
`default_nettype none
`include "safety_timing_relay_defines.vh"
module relay_checker #(
    parameter integer TICK_CYCLES = 4,
    parameter integer PRESET_W = 20,
    parameter integer TIME_W = 24
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic activation_coil_i,
    input wire logic trigger_coil_i,
    input wire logic stop_coil_i,
    input wire logic [2:0] mode_i,
    input wire logic [1:0] time_base_i,
    input wire logic [PRESET_W-1:0] first_preset_i,
    input wire logic [PRESET_W-1:0] second_preset_i,
    input wire logic enable_contact_o,
    input wire logic error_contact_o,
    input wire logic [TIME_W-1:0] elapsed_time_value_o,
    input wire logic [31:0] diagnostic_word_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [TIME_W-1:0] last_ff;
    int gap_ff;
    // Cycles since the elapsed value last moved; a stop only lengthens the gap
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_ff <= '0;
            gap_ff <= 0;
        end else begin
            last_ff <= elapsed_time_value_o;
            gap_ff <= (elapsed_time_value_o != last_ff) ? 0 : gap_ff + 1;
        end
    end
    diag_off_a: assert property (
        !activation_coil_i |=> diagnostic_word_o == `DIAG_NO_ENABLE && !enable_contact_o
            && elapsed_time_value_o == '0) else $error("idle outputs not cleared");
    diag_out_a: assert property (
        !error_contact_o |-> diagnostic_word_o[15] == enable_contact_o)
        else $error("code disagrees with contact");
    err_open_a: assert property (
        error_contact_o |-> !enable_contact_o && diagnostic_word_o == `DIAG_FAULT)
        else $error("error contact without fault state");
    bad_mode_a: assert property (
        activation_coil_i && mode_i > 3'h5 |-> ##[1:3] error_contact_o)
        else $error("bad mode not refused");
    stop_freeze_a: assert property (
        stop_coil_i |=> elapsed_time_value_o != $past(elapsed_time_value_o) + 1'b1)
        else $error("time advanced while stopped");
    elapsed_step_a: assert property (
        elapsed_time_value_o != $past(elapsed_time_value_o) |-> elapsed_time_value_o == '0
            || elapsed_time_value_o == $past(elapsed_time_value_o) + 1'b1)
        else $error("elapsed value jumped");
    tick_gap_a: assert property (
        elapsed_time_value_o != last_ff && elapsed_time_value_o != '0
            |-> gap_ff >= TICK_CYCLES - 2) else $error("ticks too close");
    early_drop_a: assert property (
        activation_coil_i && !trigger_coil_i
            && (mode_i == `MODE_ON_DELAY || mode_i == `MODE_FLASH)
        |=> !enable_contact_o) else $error("contact closed without trigger");
    off_hold_a: assert property (
        activation_coil_i && $past(activation_coil_i) && trigger_coil_i && !error_contact_o
            && (mode_i == `MODE_OFF_DELAY || mode_i == `MODE_OFF_RETRIG)
        |=> enable_contact_o) else $error("off-delay contact open while triggered");
    stop_c: cover property (stop_coil_i && diagnostic_word_o == `DIAG_STOP_ON);
    fault_c: cover property (error_contact_o);
    pause_c: cover property (diagnostic_word_o == `DIAG_WAIT_FALL_ON);
endmodule // relay_checker
bind safety_timing_relay relay_checker #(.TICK_CYCLES(TICK_CYCLES), .PRESET_W(PRESET_W),
    .TIME_W(TIME_W)) relay_checker_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .activation_coil_i(activation_coil_i), .trigger_coil_i(trigger_coil_i),
    .stop_coil_i(stop_coil_i), .mode_i(mode_i), .time_base_i(time_base_i),
    .first_preset_i(first_preset_i), .second_preset_i(second_preset_i),
    .enable_contact_o(enable_contact_o), .error_contact_o(error_contact_o),
    .elapsed_time_value_o(elapsed_time_value_o), .diagnostic_word_o(diagnostic_word_o));
`default_nettype wire

// ---- tb/coil_driver.sv ----
// Safety logic model that energises the relay coils
`timescale 1ns/1ps
`default_nettype none
module coil_driver (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic act_req_i,
    input wire logic trig_req_i,
    input wire logic stop_req_i,
    output logic activation_coil_o,
    output logic trigger_coil_o,
    output logic stop_coil_o
);
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            activation_coil_o <= 1'b0;
            trigger_coil_o <= 1'b0;
            stop_coil_o <= 1'b0;
        end else begin
            activation_coil_o <= act_req_i;
            trigger_coil_o <= trig_req_i & activation_coil_o;
            stop_coil_o <= stop_req_i;
        end
    end
endmodule // coil_driver
`default_nettype wire

// ---- tb/tb_safety_timing_relay.sv ----
// Self-checking bench for the safety timing relay
`timescale 1ns/1ps
`default_nettype none
`include "safety_timing_relay_defines.vh"
module tb_safety_timing_relay;
    localparam int TC = 4;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic act = 1'b0, trg = 1'b0, stp = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] base = 2'h0;
    logic [19:0] p1 = 20'h0, p2 = 20'h0;
    wire logic act_coil, trg_coil, stp_coil;
    logic en, er;
    logic [23:0] ev, hold;
    logic [31:0] dg;
    int mismatches = 0, samples_checked = 0, cycles = 0, n = 0, t = 0;
    integer seed = 32'hf2d0839b;
    always #2 clk_i = ~clk_i;
    coil_driver coil_driver_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .act_req_i(act),
        .trig_req_i(trg), .stop_req_i(stp), .activation_coil_o(act_coil),
        .trigger_coil_o(trg_coil), .stop_coil_o(stp_coil));
    safety_timing_relay #(.TICK_CYCLES(TC)) safety_timing_relay_inst (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .activation_coil_i(act_coil), .trigger_coil_i(trg_coil),
        .stop_coil_i(stp_coil), .mode_i(mode), .time_base_i(base), .first_preset_i(p1),
        .second_preset_i(p2), .enable_contact_o(en), .error_contact_o(er),
        .elapsed_time_value_o(ev), .diagnostic_word_o(dg));
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // Preset converted to 50 ms ticks, milliseconds rounded to the nearest step
    function automatic int ticks(input logic [1:0] b, input int p);
        if (b == `BASE_SEC) return (p + 25) / 50;
        if (b == `BASE_MIN_SEC) return p * 20;
        return p * 1200;
    endfunction
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic drv(input logic a, input logic r, input logic s);
        @(posedge clk_i);
        act <= a;
        trg <= r;
        stp <= s;
    endtask
    task automatic cfg(input logic [2:0] m, input logic [1:0] b, input logic [19:0] a,
        input logic [19:0] c);
        @(posedge clk_i);
        mode <= m;
        base <= b;
        p1 <= a;
        p2 <= c;
        act <= 1'b1;
        trg <= 1'b0;
        stp <= 1'b0;
        step(4);
    endtask
    task automatic wait_en(input logic v);
        n = 0;
        while (en !== v && n < 6000) begin
            step(1);
            n++;
        end
    endtask
    task automatic wait_dg(input logic [31:0] v);
        n = 0;
        while (dg !== v && n < 200) begin
            step(1);
            n++;
        end
        // A wait that runs out must count as a mismatch, not pass silently
        chk_w(dg, v);
    endtask
    task automatic off();
        drv(1'b0, 1'b0, 1'b0);
        step(4);
        chk_b(en, 1'b0);
        chk_w(dg, `DIAG_NO_ENABLE);
        chk_w({8'h0, ev}, 32'h0);
    endtask
    task automatic flt();
        drv(1'b1, 1'b1, 1'b0);
        step(6);
        chk_b(er, 1'b1);
        chk_w(dg, `DIAG_FAULT);
        off();
        chk_b(er, 1'b0);
    endtask
    task automatic ondly(input logic [1:0] b, input int p);
        t = ticks(b, p);
        cfg(`MODE_ON_DELAY, b, p[19:0], 20'h0);
        chk_w(dg, `DIAG_WAIT_START);
        drv(1'b1, 1'b1, 1'b0);
        wait_dg(`DIAG_RUN_OFF);
        wait_en(1'b1);
        chk_b(n >= t * TC && n <= t * TC + 2, 1'b1);
        chk_w(dg, `DIAG_ACTIVE);
        drv(1'b1, 1'b0, 1'b0);
        step(4);
        chk_b(en, 1'b0);
        chk_w(dg, `DIAG_WAIT_START);
        off();
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        ondly(`BASE_SEC, 24);
        ondly(`BASE_SEC, 25);
        ondly(`BASE_MIN_SEC, 1);
        ondly(`BASE_HR_MIN, 1);
        repeat (6) ondly(`BASE_SEC, {$random(seed)} % 1500);
        // Stop while the on-delay runs, output still open
        cfg(`MODE_ON_DELAY, `BASE_SEC, 20'h1f4, 20'h0);
        drv(1'b1, 1'b1, 1'b0);
        step(3 * TC);
        drv(1'b1, 1'b1, 1'b1);
        step(4);
        chk_w(dg, `DIAG_STOP_OFF);
        hold = ev;
        step(4 * TC);
        chk_w({8'h0, ev}, {8'h0, hold});
        chk_b(ev != 24'h0, 1'b1);
        drv(1'b1, 1'b1, 1'b0);
        wait_en(1'b1);
        chk_b(ev >= 24'ha, 1'b1);
        chk_b(en, 1'b1);
        off();
        // Early trigger drop abandons the run
        cfg(`MODE_ON_DELAY, `BASE_SEC, 20'h1f4, 20'h0);
        drv(1'b1, 1'b1, 1'b0);
        step(2 * TC);
        drv(1'b1, 1'b0, 1'b0);
        step(12 * TC);
        chk_b(en, 1'b0);
        chk_w(dg, `DIAG_WAIT_START);
        off();
        for (int m = 1; m <= 2; m++) begin
            cfg(3'(m), `BASE_SEC, 20'h1f4, 20'h0);
            drv(1'b1, 1'b1, 1'b0);
            step(4);
            chk_w(dg, `DIAG_ACTIVE);
            drv(1'b1, 1'b0, 1'b0);
            wait_dg(`DIAG_RUN_ON);
            step(2 * TC);
            drv(1'b1, 1'b0, 1'b1);
            step(4);
            chk_w(dg, `DIAG_STOP_ON);
            drv(1'b1, 1'b0, 1'b0);
            step(2 * TC);
            drv(1'b1, 1'b1, 1'b0);
            step(4);
            chk_w(dg, m == 1 ? `DIAG_WAIT_FALL_ON : `DIAG_ACTIVE);
            chk_b(ev != 24'h0, m == 1);
            drv(1'b1, 1'b0, 1'b0);
            wait_en(1'b0);
            chk_b(m == 1 ? n < 9 * TC : n >= 10 * TC, 1'b1);
            off();
        end
        // Pulse from a one-cycle trigger, then from a long one
        for (int k = 0; k < 2; k++) begin
            cfg(`MODE_PULSE, `BASE_SEC, 20'hfa, 20'h0);
            drv(1'b1, 1'b1, 1'b0);
            if (k == 0) drv(1'b1, 1'b0, 1'b0);
            wait_en(1'b1);
            wait_en(1'b0);
            chk_b(n >= 5 * TC && n <= 5 * TC + 2, 1'b1);
            if (k == 1) chk_w(dg, `DIAG_WAIT_FALL_OFF);
            off();
        end
        cfg(`MODE_FLASH, `BASE_SEC, 20'h64, 20'h96);
        drv(1'b1, 1'b1, 1'b0);
        wait_en(1'b1);
        wait_en(1'b0);
        chk_b(n >= 2 * TC && n <= 2 * TC + 2, 1'b1);
        wait_en(1'b1);
        chk_b(n >= 3 * TC && n <= 3 * TC + 2, 1'b1);
        drv(1'b1, 1'b0, 1'b0);
        step(4);
        chk_b(en, 1'b0);
        off();
        cfg(`MODE_ON_OFF, `BASE_SEC, 20'h64, 20'h96);
        drv(1'b1, 1'b1, 1'b0);
        wait_dg(`DIAG_RUN_OFF);
        wait_en(1'b1);
        chk_b(n >= 2 * TC && n <= 2 * TC + 2, 1'b1);
        drv(1'b1, 1'b0, 1'b0);
        wait_en(1'b0);
        chk_b(n >= 3 * TC && n <= 3 * TC + 4, 1'b1);
        off();
        // On-delay part cut short: contact never closes
        cfg(`MODE_ON_OFF, `BASE_SEC, 20'h64, 20'h96);
        drv(1'b1, 1'b1, 1'b0);
        step(2);
        drv(1'b1, 1'b0, 1'b0);
        step(4 * TC);
        chk_b(en, 1'b0);
        chk_w(dg, `DIAG_WAIT_START);
        off();
        // Stop while the contact is steadily closed changes nothing
        cfg(`MODE_ON_OFF, `BASE_SEC, 20'h0, 20'h96);
        drv(1'b1, 1'b1, 1'b0);
        step(4);
        drv(1'b1, 1'b1, 1'b1);
        step(4 * TC);
        chk_w(dg, `DIAG_ACTIVE);
        chk_w({8'h0, ev}, 32'h0);
        // Reset in mid-run clears everything and the block re-arms from idle
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        step(1);
        chk_b(en, 1'b0);
        chk_w(dg, `DIAG_NO_ENABLE);
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        step(2);
        chk_w(dg, `DIAG_WAIT_START);
        off();
        for (int m = 0; m < 6; m++) begin
            cfg(3'(m), `BASE_SEC, 20'h0, 20'h64);
            drv(1'b1, 1'b1, 1'b0);
            step(6);
            off();
        end
        cfg(3'h6, `BASE_SEC, 20'h0, 20'h0);
        flt();
        cfg(`MODE_ON_DELAY, 2'h3, 20'h0, 20'h0);
        flt();
        cfg(`MODE_ON_DELAY, `BASE_SEC, 20'hf4240, 20'h0);
        flt();
        // Mode changed while armed must be refused
        cfg(`MODE_ON_DELAY, `BASE_SEC, 20'h0, 20'h0);
        @(posedge clk_i);
        mode <= `MODE_PULSE;
        flt();
        results();
    end
endmodule // tb_safety_timing_relay
`default_nettype wire
